// ===== rcvd_pkg.sv
package rcvd_pkg;

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR          = 8'hC9;
  localparam logic [7:0] CTRL_RESET         = 8'h00;
  localparam int         BIT_MAIN_DIS       = 7;
  localparam int         BIT_BUS_STATUS     = 6;
  localparam int         BIT_MAIN_LP        = 4;
  localparam int         BIT_STOP_CFG       = 3;
  localparam int         BIT_CORE_LP        = 1;
  localparam int         SYNC_STAGES        = 2;

  // power state of the device as seen by the block
  typedef enum logic [1:0] {RCVD_RUN, RCVD_STOP_ON, RCVD_STOP_OFF} rcvd_pwr_t;

  // register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } rcvd_wr_t;

  // regulator control outputs
  typedef struct packed {
    logic main_enable;
    logic main_low_power;
    logic core_enable;
    logic core_low_power;
    logic power_net_enable;
  } rcvd_reg_ctl_t;

endpackage

// ===== rcvd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, first stage read only by second
module rcvd_sync
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // ----------------------------------------------------------------
  // capture chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== rcvd_top.sv
`timescale 1ns/1ps
// How it works
// (RL1) software bit switches main regulator on/off
// (RL2) status bit returns synced bus-power level
// (RL3) enabled interrupt on both bus-power edges
// (RL4) interrupt is one pulse, no pending flag
// (RL5) usb reset source resets on both edges; the code issues no usb reset while in the stop-off state
// (RL6) stop config zero keeps core regulator up
// (RL7) stop config one powers down in stop
// (RL8) mode bit picks main regulator low power
// (RL9) software avoids core low power wrongly
// (RL10) software waits 12 instructions before oscillator suspend
// (RL11) control register at 0xC9, all bits reset zero
// (RL12) disable bit one turns main regulator off
// (RL13) status reads one when bus power present
// (RL14) two-stage synchroniser before edge detection
module rcvd_top
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // register write and read
  input  wire rcvd_pkg::rcvd_wr_t reg_wr,
  input  wire logic [7:0]        reg_rd_addr,
  output logic [7:0]             reg_rd_data_q,
  // system control
  input  wire logic              vbus_pin,
  input  wire logic              vbus_irq_enable,
  input  wire logic              usb_reset_source,
  input  wire logic              stop_request,
  input  wire logic              stop_wake,
  // results
  output logic                   vbus_irq_q,
  output logic                   usb_reset_q,
  output rcvd_pkg::rcvd_reg_ctl_t reg_ctl_q,
  output logic                   pin_reset_only_q
);

  logic [7:0]          ctrl_q;
  logic                vbus_sync;
  logic                vbus_prev_q;
  logic                vbus_edge;
  rcvd_pkg::rcvd_pwr_t pwr_q;

  function automatic logic hits_ctrl(input logic [7:0] a);
    hits_ctrl = (a == rcvd_pkg::CTRL_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // bus-power sense
  // ----------------------------------------------------------------
  rcvd_sync u_sync
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (vbus_pin),
    .sync_out (vbus_sync)
  ); // RL14

  // previous level for edge detection
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      vbus_prev_q <= 1'b0;
    else if (clk_en)
      vbus_prev_q <= vbus_sync;
  end

  assign vbus_edge = vbus_sync ^ vbus_prev_q; // RL14

  // one-cycle interrupt pulse, nothing held
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      vbus_irq_q <= 1'b0;
    else if (clk_en)
      vbus_irq_q <= vbus_edge && vbus_irq_enable; // RL3 RL4
  end

  // one-cycle reset pulse when usb is a reset source
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      usb_reset_q <= 1'b0;
    else if (clk_en)
      usb_reset_q <= vbus_edge && usb_reset_source &&
                     (pwr_q != rcvd_pkg::RCVD_STOP_OFF); // RL5 RL7
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= rcvd_pkg::CTRL_RESET; // RL11
    else if (clk_en && reg_wr.wr && hits_ctrl(reg_wr.addr))
    begin
      ctrl_q <= 8'h00; // reserved and status bits hold zero
      ctrl_q[rcvd_pkg::BIT_MAIN_DIS] <= reg_wr.data[rcvd_pkg::BIT_MAIN_DIS]; // RL1 RL12
      ctrl_q[rcvd_pkg::BIT_MAIN_LP]  <= reg_wr.data[rcvd_pkg::BIT_MAIN_LP]; // RL8
      ctrl_q[rcvd_pkg::BIT_STOP_CFG] <= reg_wr.data[rcvd_pkg::BIT_STOP_CFG];
      ctrl_q[rcvd_pkg::BIT_CORE_LP]  <= reg_wr.data[rcvd_pkg::BIT_CORE_LP]; // RL9
    end
  end

  // registered read with live status bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      reg_rd_data_q <= 8'h00;
    else if (clk_en)
    begin
      if (hits_ctrl(reg_rd_addr))
      begin
        reg_rd_data_q <= ctrl_q;
        reg_rd_data_q[rcvd_pkg::BIT_BUS_STATUS] <= vbus_sync; // RL2 RL13
      end
      else
        reg_rd_data_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // stop state power
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pwr_q <= rcvd_pkg::RCVD_RUN;
    else if (clk_en)
    begin
      case (pwr_q)
        rcvd_pkg::RCVD_RUN:
          if (stop_request)
            pwr_q <= ctrl_q[rcvd_pkg::BIT_STOP_CFG] ? rcvd_pkg::RCVD_STOP_OFF
                                                    : rcvd_pkg::RCVD_STOP_ON; // RL6 RL7
        rcvd_pkg::RCVD_STOP_ON:
          if (stop_wake || usb_reset_q)
            pwr_q <= rcvd_pkg::RCVD_RUN; // RL6
        rcvd_pkg::RCVD_STOP_OFF:
          pwr_q <= rcvd_pkg::RCVD_STOP_OFF; // only pin reset leaves, RL7
        default:
          pwr_q <= rcvd_pkg::RCVD_RUN;
      endcase
    end
  end

  // regulator controls from register and power state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_ctl_q        <= '{main_enable: 1'b1, main_low_power: 1'b0, core_enable: 1'b1,
                            core_low_power: 1'b0, power_net_enable: 1'b1};
      pin_reset_only_q <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_ctl_q.main_enable      <= !ctrl_q[rcvd_pkg::BIT_MAIN_DIS]; // RL1 RL12
      reg_ctl_q.main_low_power   <= ctrl_q[rcvd_pkg::BIT_MAIN_LP]; // RL8
      reg_ctl_q.core_low_power   <= ctrl_q[rcvd_pkg::BIT_CORE_LP];
      reg_ctl_q.core_enable      <= (pwr_q != rcvd_pkg::RCVD_STOP_OFF); // RL6 RL7
      reg_ctl_q.power_net_enable <= (pwr_q != rcvd_pkg::RCVD_STOP_OFF); // RL7
      pin_reset_only_q           <= (pwr_q == rcvd_pkg::RCVD_STOP_OFF); // RL7
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_IRQ_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
    (clk_en && vbus_irq_enable && (vbus_sync != vbus_prev_q)) |=> vbus_irq_q)
    else $error("bus-power edge gave no interrupt");

  AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
    (vbus_irq_q && clk_en) |=> !vbus_irq_q || $changed(vbus_prev_q))
    else $error("interrupt held past one cycle");

  AST_RST_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
    (clk_en && usb_reset_source && vbus_edge && pwr_q != rcvd_pkg::RCVD_STOP_OFF) |=> usb_reset_q)
    else $error("usb reset missing on edge");

  AST_STATUS: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
    (clk_en && hits_ctrl(reg_rd_addr)) |=> reg_rd_data_q[rcvd_pkg::BIT_BUS_STATUS] == $past(vbus_sync))
    else $error("status bit wrong");

  AST_MAIN_DIS: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL12
    (clk_en && reg_wr.wr && hits_ctrl(reg_wr.addr)) ##1 clk_en |=>
      reg_ctl_q.main_enable == !$past(reg_wr.data[rcvd_pkg::BIT_MAIN_DIS], 2))
    else $error("main regulator enable wrong");

  AST_STOP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
    (pwr_q == rcvd_pkg::RCVD_STOP_OFF) |=> !usb_reset_q && pwr_q == rcvd_pkg::RCVD_STOP_OFF)
    else $error("stop-off state left or reset issued");

  AST_STOP_ON: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
    (clk_en && pwr_q == rcvd_pkg::RCVD_RUN && stop_request && !ctrl_q[rcvd_pkg::BIT_STOP_CFG])
      |=> pwr_q == rcvd_pkg::RCVD_STOP_ON)
    else $error("stop with core on not entered");

  AST_MAIN_LP: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
    clk_en |=> reg_ctl_q.main_low_power == $past(ctrl_q[rcvd_pkg::BIT_MAIN_LP]))
    else $error("main low power mode wrong");

  AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
    (clk_en && !vbus_irq_enable) |=> !vbus_irq_q)
    else $error("interrupt raised while disabled");

  AST_RST_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
    (clk_en && !usb_reset_source) |=> !usb_reset_q)
    else $error("usb reset raised while not a source");

  AST_CORE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
    (clk_en && pwr_q == rcvd_pkg::RCVD_STOP_OFF) |=>
      !reg_ctl_q.core_enable && !reg_ctl_q.power_net_enable && pin_reset_only_q)
    else $error("core supply not shut down in stop");

  AST_CORE_ON: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
    (clk_en && pwr_q != rcvd_pkg::RCVD_STOP_OFF) |=> reg_ctl_q.core_enable && !pin_reset_only_q)
    else $error("core supply dropped outside stop-off");

endmodule

// ===== rcvd_host_model.sv
`timescale 1ns/1ps
// bus-power line of the host side
module rcvd_host_model
(
  // attach request from the bench
  input  wire logic attach,
  // bus-power line, clean edge a few ns after attach
  output logic      vbus_pin
);
  // no bounce; the edge lands away from any clock edge
  assign #3 vbus_pin = attach;
endmodule

// ===== rcvd_top_test.sv
`timescale 1ns/1ps
module rcvd_top_test;
  logic                    clk_sys, rst_b, clk_en, attach, irq_en, rst_src, stop_req, stop_wake;
  logic                    vbus_pin, irq, usb_rst, pin_only;
  logic [7:0]              rd_addr, rd_data;
  rcvd_pkg::rcvd_wr_t      wr;
  rcvd_pkg::rcvd_reg_ctl_t ctl;
  int                      fail_count, n_compared, n_irq, n_rst;

  rcvd_host_model rcvd_host_model_inst (.attach(attach), .vbus_pin(vbus_pin));
  rcvd_top rcvd_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(wr),
    .reg_rd_addr(rd_addr), .reg_rd_data_q(rd_data), .vbus_pin(vbus_pin), .vbus_irq_enable(irq_en),
    .usb_reset_source(rst_src), .stop_request(stop_req), .stop_wake(stop_wake), .vbus_irq_q(irq),
    .usb_reset_q(usb_rst), .reg_ctl_q(ctl), .pin_reset_only_q(pin_only));

  // 50 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // write, returns once reg_ctl_q has followed
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    wr = '{1'b1, a, d};
    @(negedge clk_sys);
    wr.wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // read with registered answer
  task automatic read(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    rd_addr = a;
    @(negedge clk_sys);
    chk("read", exp, rd_data);
  endtask

  // one bus-power edge, pulses counted over eight cycles
  task automatic edge_count(input logic lvl);
    n_irq = 0;
    n_rst = 0;
    @(negedge clk_sys);
    attach = lvl;
    repeat (8)
    begin
      @(negedge clk_sys);
      if (irq === 1'b1) n_irq++;
      if (usb_rst === 1'b1) n_rst++;
    end
  endtask

  // stop request, outputs settle two edges on
  task automatic stop_pulse();
    @(negedge clk_sys);
    stop_req = 1'b1;
    @(negedge clk_sys);
    stop_req = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    {clk_en, attach, irq_en, rst_src, stop_req, stop_wake} = 6'b100000;
    wr = '0;
    rd_addr = 8'hC9;
    rst_b = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("ctl", 8'h15, {3'h0, ctl});
    read(8'hC9, 8'h00);
    write(8'hC9, 8'h3F);
    repeat (12) @(negedge clk_sys);
    read(8'hC9, 8'h1A);
    chk("ctl", 8'h1F, {3'h0, ctl});
    write(8'hC9, 8'h80);
    chk("ctl", 8'h05, {3'h0, ctl});
    write(8'hC8, 8'h00);
    read(8'hC9, 8'h80);
    read(8'hC8, 8'h00);
    clk_en = 1'b0;
    write(8'hC9, 8'h00);
    clk_en = 1'b1;
    read(8'hC9, 8'h80);
    write(8'hC9, 8'h00);
    chk("ctl", 8'h15, {3'h0, ctl});
    irq_en = 1'b1;
    edge_count(1'b1);
    chk("irq", 8'h01, 8'(n_irq));
    chk("rst", 8'h00, 8'(n_rst));
    read(8'hC9, 8'h40);
    rst_src = 1'b1;
    edge_count(1'b0);
    chk("irq", 8'h01, 8'(n_irq));
    chk("rst", 8'h01, 8'(n_rst));
    read(8'hC9, 8'h00);
    {irq_en, rst_src} = 2'b00;
    edge_count(1'b1);
    chk("irq", 8'h00, 8'(n_irq));
    chk("rst", 8'h00, 8'(n_rst));
    rst_src = 1'b1;
    stop_pulse();
    chk("core", 8'h01, {7'h0, ctl.core_enable});
    chk("pinonly", 8'h00, {7'h0, pin_only});
    edge_count(1'b0);
    chk("rst", 8'h01, 8'(n_rst));
    // stop with core on, then wake by stop_wake
    stop_pulse();
    write(8'hC9, 8'h08);
    stop_pulse();
    chk("pinonly", 8'h00, {7'h0, pin_only});
    stop_wake = 1'b1;
    @(negedge clk_sys);
    stop_wake = 1'b0;
    stop_pulse();
    chk("core", 8'h00, {6'h0, ctl.core_enable, ctl.power_net_enable});
    chk("pinonly", 8'h01, {7'h0, pin_only});
    stop_wake = 1'b1;
    edge_count(1'b1);
    chk("rst", 8'h00, 8'(n_rst));
    chk("pinonly", 8'h01, {7'h0, pin_only});
    stop_wake = 1'b0;
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk("pinonly", 8'h00, {7'h0, pin_only});
    print_verdict();
  end
endmodule
